// ### inc/isse_pkg.sv
package isse_pkg;

  // address constants and counts
  localparam logic [4:0] TEN_PREFIX = 5'h1E;
  localparam logic [7:0] GC_ADDR    = 8'h00;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] CNT_RST    = 4'h0;
  localparam int         TX_DEPTH   = 2;
  localparam int         BYTE_W     = 8;

  // byte engine states
  typedef enum logic [2:0] {
    ISSE_IDLE  = 3'b000,
    ISSE_ADDR  = 3'b001,
    ISSE_ADDR2 = 3'b010,
    ISSE_RXD   = 3'b011,
    ISSE_TXD   = 3'b100,
    ISSE_ACK   = 3'b101,
    ISSE_TXACK = 3'b110
  } isse_state_type;

  // software configuration bits
  typedef struct packed {
    logic [9:0] own_address_reg;
    logic       ten_bit_addr_select;
    logic       rx_stretch_enable;
    logic       general_call_enable;
    logic       accept_all_enable;
    logic       slope_limit_disable;
  } isse_cfg_type;

  // sampled bus view
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } isse_bus_type;

  // pin synchroniser state
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
  } isse_sync_type;

  // engine state
  typedef struct packed {
    isse_state_type state;
    isse_state_type after;
    logic [3:0]     cnt;
    logic [7:0]     shift;
    logic [7:0]     rx_byte;
    logic           rx_full;
    logic           rx_ov;
    logic           rel;
    logic           hold;
    logic           ten_match;
    logic           ack_drive;
    logic           gc;
    logic           addr;
    logic           loaded;
    logic           master_ack;
    logic           sda_oe;
    logic           slv_ev;
    logic           mst_ev;
    logic           slope_off;
    logic           tx_mode;
  } isse_core_type;

  localparam isse_sync_type SYNC_RST = '1;
  localparam isse_core_type CORE_RST = '{state: ISSE_IDLE,
                                         after: ISSE_IDLE,
                                         rel: 1'b1,
                                         default: '0};

endpackage

// ### logic/isse_pin_sync.sv
`timescale 1ns/10ps
module isse_pin_sync
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  // bus pins
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  // sampled view
  output isse_pkg::isse_bus_type     bus
);

  isse_pkg::isse_sync_type st;
  isse_pkg::isse_sync_type next_st;

  // two stages, then one delay stage for edges
  always_comb
  begin
    next_st       = st;
    next_st.scl_m = scl_in;
    next_st.scl_s = st.scl_m;
    next_st.scl_d = st.scl_s;
    next_st.sda_m = sda_in;
    next_st.sda_s = st.sda_m;
    next_st.sda_d = st.sda_s;
  end

  // bus idles high
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      st <= isse_pkg::SYNC_RST;
    else
      st <= next_st;
  end

  // edges and conditions from settled samples only
  assign bus.scl      = st.scl_s;
  assign bus.sda      = st.sda_s;
  assign bus.scl_rise = st.scl_s & ~st.scl_d;
  assign bus.scl_fall = ~st.scl_s & st.scl_d;
  assign bus.start    = st.scl_s & st.scl_d & st.sda_d & ~st.sda_s;
  assign bus.stop     = st.scl_s & st.scl_d & ~st.sda_d & st.sda_s;

endmodule

// ### logic/isse_tx_fifo.sv
`timescale 1ns/10ps
module isse_tx_fifo
#(
  parameter int W     = 8,
  parameter int DEPTH = 2
)
(
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // filling side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // draining side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  localparam int          AW       = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wr;
    logic [AW:0]             rd;
    logic                    full;
    logic                    empty;
  } isse_fifo_type;

  isse_fifo_type st;
  isse_fifo_type next_st;
  logic          push;
  logic          take;
  logic [AW:0]   used;

  assign push = in_valid && !st.full;
  assign take = out_ready && !st.empty;

  // pointers wrap one bit wider so full and empty differ
  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wr[AW-1:0]] = in_data;
      next_st.wr                 = st.wr + 1'b1;
    end
    if (take)
      next_st.rd = st.rd + 1'b1;
    used          = next_st.wr - next_st.rd;
    next_st.full  = (used == FULL_CNT);
    next_st.empty = (used == '0);
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      st <= '{empty: 1'b1, default: '0};
    else
      st <= next_st;
  end

  // flags are registered, head word read by index
  assign in_ready  = !st.full;
  assign out_valid = !st.empty;
  assign out_data  = st.mem[st.rd[AW-1:0]];

endmodule

// ### logic/isse_slave_engine.sv
`timescale 1ns/10ps
// Contract
// - read address acked, hold SCL if buffer empty until release set
// - transmit eight bits, change SDA on fall
// - transmit byte pulses slave event at ninth fall
// - write address receives; load and ack if free
// - full buffer: no ack, no load, still pulse
// - overflow but empty: load, answer not-ack
// - ten-bit first byte prefix and high bits
// - ten-bit second byte against low bits
// - repeated start read after full ten-bit match
// - transmit ack with empty buffer clears release
// - byte loaded before ninth fall, no stretch
// - stretch enabled and full: clear release, hold
// - buffer read before ninth fall, no stretch
// - software may set release at any time
// - ten-bit stretch in address phase and data
// - hold SCL only after falling edge seen
// - stretch disabled ignores release clears
// - separate master and slave event flags
// - slope limit disable control bit
// - accept-all matches every address
// - general call compare when enabled
// - general call loads buffer, master event
// - seven-bit compare, bit zero is direction
// - address match acks, slave event, buffer kept
// - select seven or ten bit matching
module isse_slave_engine
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  // two-wire pins
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       scl_out,
  output logic                       scl_oe,
  output logic                       sda_out,
  output logic                       sda_oe,
  // configuration
  input  wire isse_pkg::isse_cfg_type cfg,
  // software strobes
  input  wire logic                  rel_set,
  input  wire logic                  rel_clear,
  input  wire logic                  rx_read,
  input  wire logic                  ov_clear,
  // transmit byte stream
  input  wire logic                  tx_valid,
  input  wire logic [7:0]            tx_data,
  output logic                       tx_ready,
  // status
  output logic [7:0]                 rx_byte_reg,
  output logic                       rx_full_flag,
  output logic                       rx_overflow_flag,
  output logic                       tx_full_flag,
  output logic                       clock_release_bit,
  output logic                       ten_bit_match_flag,
  output logic                       slave_event_flag,
  output logic                       master_event_flag,
  output logic                       slope_limit_off,
  output logic                       tx_mode
);

  isse_pkg::isse_core_type st;
  isse_pkg::isse_core_type next_st;
  isse_pkg::isse_bus_type  bus;
  logic                    tx_full;
  logic [7:0]              tx_head;
  logic                    pop;
  logic                    hit7;
  logic                    hit10;
  logic                    gc_hit;
  logic                    rw;
  logic                    aa;

  // pin sampling and edge finding
  isse_pin_sync u_sync
  (
    .mclk   (mclk),
    .rstn   (rstn),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .bus    (bus)
  );

  // transmit bytes wait here until loaded into the shift register
  isse_tx_fifo
  #(
    .W     (isse_pkg::BYTE_W),
    .DEPTH (isse_pkg::TX_DEPTH)
  )
  u_fifo
  (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (tx_valid),
    .in_data   (tx_data),
    .in_ready  (tx_ready),
    .out_valid (tx_full),
    .out_data  (tx_head),
    .out_ready (pop)
  );

  // address decode on the completed byte
  assign rw     = st.shift[0];
  assign aa     = cfg.accept_all_enable;
  assign hit7   = cfg.own_address_reg[6:0] == st.shift[7:1];
  assign hit10  = st.shift[7:3] == isse_pkg::TEN_PREFIX
               && st.shift[2:1] == cfg.own_address_reg[9:8];
  assign gc_hit = cfg.general_call_enable
               && st.shift == isse_pkg::GC_ADDR;

  // byte engine
  always_comb
  begin
    next_st           = st;
    pop               = 1'b0;
    next_st.slv_ev    = 1'b0;
    next_st.mst_ev    = 1'b0;
    next_st.slope_off = cfg.slope_limit_disable;
    // software clears come first so hardware sets win
    if (rx_read)
      next_st.rx_full = 1'b0;
    if (ov_clear)
      next_st.rx_ov = 1'b0;
    if (rel_clear && cfg.rx_stretch_enable)
      next_st.rel = 1'b0;
    case (st.state)
      isse_pkg::ISSE_ADDR,
      isse_pkg::ISSE_ADDR2,
      isse_pkg::ISSE_RXD:
      begin
        if (bus.scl_rise && st.cnt != isse_pkg::BYTE_BITS)
        begin
          next_st.shift = {st.shift[6:0], bus.sda};
          next_st.cnt   = st.cnt + 4'h1;
        end
        else if (bus.scl_fall && st.cnt == isse_pkg::BYTE_BITS)
        begin
          next_st.cnt       = isse_pkg::CNT_RST;
          next_st.state     = isse_pkg::ISSE_ACK;
          next_st.ack_drive = 1'b1;
          next_st.gc        = 1'b0;
          next_st.addr      = st.state != isse_pkg::ISSE_RXD;
          next_st.after     = isse_pkg::ISSE_RXD;
          if (st.state == isse_pkg::ISSE_RXD)
          begin
            if (st.rx_full)
            begin
              next_st.ack_drive = 1'b0;
              next_st.rx_ov     = 1'b1;
            end
            else
            begin
              next_st.rx_byte   = st.shift;
              next_st.rx_full   = 1'b1;
              next_st.ack_drive = !st.rx_ov;
            end
          end
          else if (st.state == isse_pkg::ISSE_ADDR2)
          begin
            if (aa || st.shift == cfg.own_address_reg[7:0])
              next_st.ten_match = 1'b1;
            else
            begin
              next_st.ten_match = 1'b0;
              next_st.state     = isse_pkg::ISSE_IDLE;
            end
          end
          else if (gc_hit && !rw)
          begin
            next_st.gc      = 1'b1;
            next_st.rx_byte = st.shift;
            next_st.rx_full = 1'b1;
          end
          else if (aa || (!cfg.ten_bit_addr_select && hit7))
          begin
            // buffer untouched by own address
            if (rw)
              next_st.after = isse_pkg::ISSE_TXD;
          end
          else if (cfg.ten_bit_addr_select && hit10 && !rw)
          begin
            next_st.ten_match = 1'b0;
            next_st.after     = isse_pkg::ISSE_ADDR2;
          end
          else if (cfg.ten_bit_addr_select && hit10 && st.ten_match)
            next_st.after = isse_pkg::ISSE_TXD;
          else
          begin
            next_st.ten_match = 1'b0;
            next_st.state     = isse_pkg::ISSE_IDLE;
          end
        end
      end
      isse_pkg::ISSE_ACK:
      begin
        if (bus.scl_fall)
        begin
          next_st.state  = st.after;
          next_st.loaded = 1'b0;
          next_st.mst_ev = st.gc;
          next_st.slv_ev = !st.gc;
          if (st.after == isse_pkg::ISSE_TXD)
          begin
            if (!tx_full)
              next_st.rel = 1'b0;
          end
          else if (cfg.rx_stretch_enable
                   && ((st.addr && cfg.ten_bit_addr_select)
                       || (!st.addr && st.rx_full)))
            next_st.rel = 1'b0;
        end
      end
      isse_pkg::ISSE_TXD:
      begin
        if (!st.loaded)
        begin
          if (tx_full)
          begin
            next_st.shift  = tx_head;
            next_st.loaded = 1'b1;
            pop            = 1'b1;
          end
        end
        else if (bus.scl_rise && st.cnt != isse_pkg::BYTE_BITS)
          next_st.cnt = st.cnt + 4'h1;
        else if (bus.scl_fall && st.cnt == isse_pkg::BYTE_BITS)
        begin
          next_st.cnt   = isse_pkg::CNT_RST;
          next_st.state = isse_pkg::ISSE_TXACK;
        end
        else if (bus.scl_fall && st.cnt != isse_pkg::CNT_RST)
          next_st.shift = {st.shift[6:0], 1'b0};
      end
      isse_pkg::ISSE_TXACK:
      begin
        if (bus.scl_rise)
          next_st.master_ack = !bus.sda;
        if (bus.scl_fall)
        begin
          next_st.slv_ev = 1'b1;
          if (st.master_ack)
          begin
            next_st.state  = isse_pkg::ISSE_TXD;
            next_st.loaded = 1'b0;
            if (!tx_full)
              next_st.rel = 1'b0;
          end
          else
            next_st.state = isse_pkg::ISSE_IDLE;
        end
      end
      default:
        next_st.cnt = isse_pkg::CNT_RST;
    endcase
    // start and stop override any byte in progress
    if (bus.start)
    begin
      next_st.state = isse_pkg::ISSE_ADDR;
      next_st.cnt   = isse_pkg::CNT_RST;
    end
    else if (bus.stop)
    begin
      next_st.state     = isse_pkg::ISSE_IDLE;
      next_st.ten_match = 1'b0;
    end
    if (rel_set)
      next_st.rel = 1'b1;
    // hold only from a seen falling edge, low until released
    next_st.hold    = !next_st.rel
                   && (st.hold || bus.scl_fall);
    next_st.sda_oe  = (next_st.state == isse_pkg::ISSE_ACK
                       && next_st.ack_drive)
                   || (next_st.state == isse_pkg::ISSE_TXD
                       && next_st.loaded
                       && !next_st.shift[7]);
    next_st.tx_mode = next_st.state == isse_pkg::ISSE_TXD
                   || next_st.state == isse_pkg::ISSE_TXACK;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      st <= isse_pkg::CORE_RST;
    else
      st <= next_st;
  end

  // outputs straight from state
  assign scl_out            = 1'b0;
  assign sda_out            = 1'b0;
  assign scl_oe             = st.hold;
  assign sda_oe             = st.sda_oe;
  assign rx_byte_reg        = st.rx_byte;
  assign rx_full_flag       = st.rx_full;
  assign rx_overflow_flag   = st.rx_ov;
  assign tx_full_flag       = tx_full;
  assign clock_release_bit  = st.rel;
  assign ten_bit_match_flag = st.ten_match;
  assign slave_event_flag   = st.slv_ev;
  assign master_event_flag  = st.mst_ev;
  assign slope_limit_off    = st.slope_off;
  assign tx_mode            = st.tx_mode;

  // checks on the engine
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  read_hold_a: assert property (
    st.state == isse_pkg::ISSE_ACK && bus.scl_fall && !rel_set
    && st.after == isse_pkg::ISSE_TXD && !tx_full
    |=> scl_oe && tx_mode)
    else $error("read address did not hold SCL");
  tx_change_a: assert property (
    st.state == isse_pkg::ISSE_TXD && st.loaded && $past(st.loaded)
    && $past(st.state) == isse_pkg::ISSE_TXD && $changed(st.sda_oe)
    |-> $past(bus.scl_fall))
    else $error("transmit SDA changed off a falling edge");
  tx_event_a: assert property (
    st.state == isse_pkg::ISSE_TXACK && bus.scl_fall
    |=> slave_event_flag)
    else $error("no slave event after transmit byte");
  rx_load_a: assert property (
    st.state == isse_pkg::ISSE_RXD && bus.scl_fall
    && st.cnt == isse_pkg::BYTE_BITS && !st.rx_full && !st.rx_ov
    |=> rx_full_flag && sda_oe ##1 !bus.scl_fall [*1])
    else $error("free buffer not loaded and acked");
  full_nack_a: assert property (
    st.state == isse_pkg::ISSE_RXD && bus.scl_fall
    && st.cnt == isse_pkg::BYTE_BITS && st.rx_full
    |=> !sda_oe && rx_overflow_flag && $stable(rx_byte_reg))
    else $error("full buffer handled wrongly");
  ov_nack_a: assert property (
    st.state == isse_pkg::ISSE_RXD && bus.scl_fall
    && st.cnt == isse_pkg::BYTE_BITS && !st.rx_full && st.rx_ov
    |=> rx_full_flag && !sda_oe)
    else $error("overflow byte acked or not loaded");
  ten_miss_a: assert property (
    st.state == isse_pkg::ISSE_ADDR && bus.scl_fall
    && st.cnt == isse_pkg::BYTE_BITS && cfg.ten_bit_addr_select
    && !aa && !gc_hit && !hit10
    |=> st.state == isse_pkg::ISSE_IDLE && !ten_bit_match_flag)
    else $error("ten-bit mismatch not idled");
  tx_stretch_a: assert property (
    st.state == isse_pkg::ISSE_TXACK && bus.scl_fall
    && st.master_ack && !tx_full && !rel_set
    |=> !clock_release_bit ##1 scl_oe || clock_release_bit)
    else $error("acked transmit with empty buffer not held");
  rx_stretch_a: assert property (
    st.state == isse_pkg::ISSE_ACK && bus.scl_fall && !st.addr
    && st.after == isse_pkg::ISSE_RXD && cfg.rx_stretch_enable
    && st.rx_full && !rel_set
    |=> !clock_release_bit && scl_oe)
    else $error("full receive buffer not stretched");
  rel_set_a: assert property (
    rel_set |=> clock_release_bit && !scl_oe)
    else $error("release set did not free SCL");
  hold_edge_a: assert property (
    $rose(scl_oe) |-> $past(bus.scl_fall))
    else $error("SCL held without a falling edge");
  rel_keep_a: assert property (
    !cfg.rx_stretch_enable && st.rel && rel_clear && !bus.scl_fall
    |=> clock_release_bit)
    else $error("release cleared with stretch disabled");

  tx_byte_c: cover property (
    st.state == isse_pkg::ISSE_TXACK && bus.scl_fall);
  rx_byte_c: cover property (
    st.state == isse_pkg::ISSE_RXD && bus.scl_fall
    && st.cnt == isse_pkg::BYTE_BITS);
  gc_c: cover property (master_event_flag);
  stretch_c: cover property (scl_oe [*3] ##1 !scl_oe);

endmodule

// ### tb/isse_bus_master.sv
`timescale 1ns/10ps
module isse_bus_master
(
  // device pull-downs
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  // wire levels
  output logic      scl,
  output logic      sda
);
  logic m_scl_low;
  logic m_sda_low;
  logic hung;

  // bus idle, both lines released
  initial
  begin
    m_scl_low = 1'b0;
    m_sda_low = 1'b0;
    hung      = 1'b0;
  end

  // open-drain wires with pull-ups
  assign scl = ~(m_scl_low | scl_oe);
  assign sda = ~(m_sda_low | sda_oe);

  // release scl, wait out any stretch under a bound
  task wait_high();
    int n;
    m_scl_low = 1'b0;
    n = 0;
    while (scl !== 1'b1 && n < 2000)
    begin
      #10;
      n++;
    end
    if (n == 2000)
      hung = 1'b1;
  endtask

  // one clock: data set mid-low, sampled at the rise
  task bit_io(input logic b, output logic r);
    m_sda_low = ~b;
    #150;
    wait_high();
    r = sda;
    #100;
    m_scl_low = 1'b1;
    #150;
  endtask

  // start or repeated start
  task start();
    m_sda_low = 1'b0;
    #150;
    wait_high();
    #100;
    m_sda_low = 1'b1;
    #100;
    m_scl_low = 1'b1;
    #150;
  endtask

  // stop, leaves the bus idle
  task stop();
    m_sda_low = 1'b1;
    #150;
    wait_high();
    #100;
    m_sda_low = 1'b0;
    #200;
  endtask

  // eight bits msb first, then the ninth bit
  task byte_io(input logic [7:0] d, input logic a,
               output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(a, r);
  endtask
endmodule

// ### tb/isse_slave_engine_tb.sv
`timescale 1ns/10ps
module isse_slave_engine_tb;
  logic                   mclk, rstn, scl, sda, scl_oe, sda_oe, r;
  logic                   rel_set, rel_clear, rx_read, ov_clear;
  logic                   tx_valid, tx_ready, tx_full_flag, tx_mode;
  logic [7:0]             tx_data, rx_byte_reg, q;
  logic                   rx_full_flag, rx_overflow_flag;
  logic                   clock_release_bit, ten_bit_match_flag;
  logic                   slave_event_flag, master_event_flag;
  logic                   slope_limit_off;
  isse_pkg::isse_cfg_type cfg;
  int                     num_errors, checks, n_sev, n_mev;

  isse_slave_engine dut_u
  (
    .mclk(mclk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
    .scl_out(), .scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe),
    .cfg(cfg), .rel_set(rel_set), .rel_clear(rel_clear),
    .rx_read(rx_read), .ov_clear(ov_clear), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_byte_reg(rx_byte_reg),
    .rx_full_flag(rx_full_flag), .rx_overflow_flag(rx_overflow_flag),
    .tx_full_flag(tx_full_flag), .clock_release_bit(clock_release_bit),
    .ten_bit_match_flag(ten_bit_match_flag),
    .slave_event_flag(slave_event_flag),
    .master_event_flag(master_event_flag),
    .slope_limit_off(slope_limit_off), .tx_mode(tx_mode)
  );

  isse_bus_master mst_u
  (
    .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda)
  );

  // clock
  initial
    mclk = 1'b0;
  always #25 mclk = ~mclk;

  // event pulse counters
  always @(posedge mclk)
  begin
    if (slave_event_flag === 1'b1)
      n_sev++;
    if (master_event_flag === 1'b1)
      n_mev++;
  end

  // compare and report
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", s, e, g);
      num_errors++;
    end
  endtask

  // one-cycle software strobes {rel_set,rel_clear,rx_read,ov_clear}
  task sw(input logic [3:0] s);
    @(negedge mclk);
    {rel_set, rel_clear, rx_read, ov_clear} = s;
    @(negedge mclk);
    {rel_set, rel_clear, rx_read, ov_clear} = 4'h0;
  endtask

  // software write of one transmit byte
  task push(input logic [7:0] d);
    int n;
    @(negedge mclk);
    tx_valid = 1'b1;
    tx_data  = d;
    n = 0;
    // ready is looked at while settled; the next rise takes the byte
    while (tx_ready !== 1'b1 && n < 100)
    begin
      @(negedge mclk);
      n++;
    end
    if (n == 100)
      num_errors++;
    @(negedge mclk);
    tx_valid = 1'b0;
  endtask

  // master transfers
  task adr(input logic [7:0] a, input logic e);
    mst_u.start();
    mst_u.byte_io(a, 1'b1, q, r);
    chk("address ack", {7'h00, e}, {7'h00, r});
  endtask

  task wr(input logic [7:0] d, input logic e);
    mst_u.byte_io(d, 1'b1, q, r);
    chk("data ack", {7'h00, e}, {7'h00, r});
  endtask

  task rd(input logic [7:0] e, input logic a);
    mst_u.byte_io(8'hFF, a, q, r);
    chk("read data", e, q);
  endtask

  // verdict
  task end_sim();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #5ms;
    num_errors++;
    end_sim();
  end

  // main sequence
  initial
  begin
    rstn = 1'b0;
    {rel_set, rel_clear, rx_read, ov_clear} = 4'h0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    cfg = '{own_address_reg: 10'h052, default: '0};
    num_errors = 0;
    checks = 0;
    n_sev = 0;
    n_mev = 0;
    repeat (5) @(negedge mclk);
    rstn = 1'b1;
    repeat (4) @(negedge mclk);
    chk("release", 8'h01, clock_release_bit);
    chk("tx ready", 8'h01, tx_ready);
    // 7-bit write: plain, full and overflow bytes
    adr(8'hA4, 1'b0);
    chk("rx full", 8'h00, rx_full_flag);
    wr(8'hA5, 1'b0);
    wr(8'h3C, 1'b1);
    chk("rx byte", 8'hA5, rx_byte_reg);
    chk("overflow", 8'h01, rx_overflow_flag);
    sw(4'h2);
    wr(8'h3C, 1'b1);
    chk("rx byte", 8'h3C, rx_byte_reg);
    mst_u.stop();
    chk("slave events", 8'h04, n_sev[7:0]);
    sw(4'h3);
    // release clears with and without stretching
    sw(4'h4);
    chk("release", 8'h01, clock_release_bit);
    cfg.rx_stretch_enable = 1'b1;
    sw(4'h4);
    repeat (4) @(negedge mclk);
    chk("release", 8'h00, clock_release_bit);
    chk("scl hold", 8'h00, scl_oe);
    sw(4'h8);
    adr(8'hA4, 1'b0);
    wr(8'h11, 1'b0);
    repeat (4) @(negedge mclk);
    chk("release", 8'h00, clock_release_bit);
    chk("scl hold", 8'h01, scl_oe);
    sw(4'h2);
    sw(4'h8);
    repeat (2) @(negedge mclk);
    chk("scl hold", 8'h00, scl_oe);
    mst_u.stop();
    // 7-bit read with transmit buffer filled while stalled
    @(negedge mclk);
    cfg.rx_stretch_enable = 1'b0;
    n_sev = 0;
    adr(8'hA5, 1'b0);
    repeat (4) @(negedge mclk);
    chk("release", 8'h00, clock_release_bit);
    chk("scl hold", 8'h01, scl_oe);
    chk("tx mode", 8'h01, tx_mode);
    push(8'hC3);
    push(8'h5A);
    push(8'h7E);
    repeat (2) @(negedge mclk);
    chk("tx ready", 8'h00, tx_ready);
    chk("tx full", 8'h01, tx_full_flag);
    sw(4'h8);
    rd(8'hC3, 1'b0);
    chk("release", 8'h01, clock_release_bit);
    rd(8'h5A, 1'b0);
    rd(8'h7E, 1'b1);
    chk("tx full", 8'h00, tx_full_flag);
    mst_u.stop();
    chk("slave events", 8'h04, n_sev[7:0]);
    // 10-bit match, then repeated start read
    @(negedge mclk);
    cfg.ten_bit_addr_select = 1'b1;
    cfg.own_address_reg = 10'h2A7;
    adr(8'hF6, 1'b1);
    adr(8'hF4, 1'b0);
    chk("ten match", 8'h00, ten_bit_match_flag);
    wr(8'hA7, 1'b0);
    chk("ten match", 8'h01, ten_bit_match_flag);
    adr(8'hF5, 1'b0);
    push(8'h96);
    sw(4'h8);
    rd(8'h96, 1'b1);
    mst_u.stop();
    // general call, accept-all, slope control
    @(negedge mclk);
    cfg = '{own_address_reg: 10'h052, general_call_enable: 1'b1,
            slope_limit_disable: 1'b1, default: '0};
    n_mev = 0;
    adr(8'h00, 1'b0);
    chk("rx byte", 8'h00, rx_byte_reg);
    chk("rx full", 8'h01, rx_full_flag);
    mst_u.stop();
    chk("master events", 8'h01, n_mev[7:0]);
    chk("slope off", 8'h01, slope_limit_off);
    sw(4'h2);
    adr(8'h26, 1'b1);
    @(negedge mclk);
    cfg.accept_all_enable = 1'b1;
    adr(8'h26, 1'b0);
    mst_u.stop();
    chk("bus hang", 8'h00, {7'h00, mst_u.hung});
    end_sim();
  end
endmodule
